// ### inc/fep_map.svh
// Register map, field positions, reset values and ranges of the protection block
`ifndef FEP_MAP_SVH
`define FEP_MAP_SVH

// Register word indices, byte address is index times four
`define FEP_IDX_CONFIG 6'h04
`define FEP_IDX_ERR_CONFIG 6'h05
`define FEP_IDX_STATUS 6'h06
`define FEP_IDX_ERR_FLAGS 6'h07
`define FEP_IDX_PROT 6'h08

// Bit positions inside the registers
`define FEP_SINGLE_FAULT_BIT 0
`define FEP_DOUBLE_FAULT_BIT 1
`define FEP_IGNORE_SF_BIT 4
`define FEP_SF_IRQ_EN_BIT 0
`define FEP_VIOL_BIT 4

// Protection register values
`define FEP_PROT_FULL 8'h7F
`define FEP_PROT_WR_MASK 8'hBF
`define FEP_NV_PROT_ADDR 24'hFF_FE0C

// Allowed scenario moves, bit index is from times eight plus to
`define FEP_TRANS_TABLE 64'hFF5A_3C18_080C_0A0F

// Address ranges of the program array
`define FEP_TOP_ADDR 24'hFF_FFFF
`define FEP_LOW_BASE 24'hFF_8000
`define FEP_HIGH_MIN_BYTES 24'h00_0800
`define FEP_LOW_MIN_BYTES 24'h00_0400

// Cycles from an array read to its stored read event, the fault flag follows one cycle later
`define FEP_FAULT_DELAY 1

`endif

// ### inc/fep_pkg.sv
// Types shared by the protection block modules
package fep_pkg;

   typedef logic [23:0] fep_addr_t;

   typedef enum logic [1:0] {
      FEP_TR_IDLE = 2'b00,
      FEP_TR_BUSY = 2'b01,
      FEP_TR_NONSEQ = 2'b10,
      FEP_TR_SEQ = 2'b11
   } fep_htrans_t;

   typedef struct packed {
      logic polarity;
      logic reserved_nv_bit;
      logic high_disable;
      logic [1:0] high_size;
      logic low_disable;
      logic [1:0] low_size;
   } fep_prot_t;

endpackage : fep_pkg

// ### inc/fep_prot_if.sv
// Interface between the control logic and the range checker
`timescale 1ns/1ps
`default_nettype none

interface fep_prot_if;
   import fep_pkg::*;

   fep_prot_t prot;
   fep_addr_t addr;
   logic is_protected;
   logic block_locked;

   modport range (
      input prot,
      input addr,
      output is_protected,
      output block_locked
   );

   modport ctrl (
      output prot,
      output addr,
      input is_protected,
      input block_locked
   );

endinterface : fep_prot_if

`default_nettype wire

// ### rtl/fep_range_check.sv
// Decodes the protected high and low ranges and checks one target address
`timescale 1ns/1ps
`default_nettype none
`include "fep_map.svh"

module fep_range_check
   import fep_pkg::*;
(
   // Protection setting and target
   fep_prot_if.range pif
);

   logic in_high;
   logic in_low;
   logic hit_high;
   logic hit_low;

   // Region size in bytes from its smallest size and size code
   function automatic fep_addr_t fep_span(input fep_addr_t base, input logic [1:0] code);
      fep_span = base << code;
   endfunction : fep_span

   // High region ends at the top address, low region starts at the base
   assign in_high = pif.addr > (`FEP_TOP_ADDR - fep_span(`FEP_HIGH_MIN_BYTES,
      pif.prot.high_size));
   assign in_low = (pif.addr >= `FEP_LOW_BASE) &&
      (pif.addr < (`FEP_LOW_BASE + fep_span(`FEP_LOW_MIN_BYTES,
      pif.prot.low_size)));

   assign hit_high = !pif.prot.high_disable && in_high;
   assign hit_low = !pif.prot.low_disable && in_low;

   // Polarity one protects the ranges, zero leaves only them open
   assign pif.is_protected = pif.prot.polarity ? (hit_high || hit_low)
      : !(hit_high || hit_low);

   // Any protected sector blocks a whole-block erase
   assign pif.block_locked = pif.prot.polarity ?
      (!pif.prot.high_disable || !pif.prot.low_disable) : 1'b1;

endmodule : fep_range_check

`default_nettype wire

// ### rtl/fep_top.sv
// Flash error flags and program-flash protection register block
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fep_map.svh"

// What this block does
// - Double fault or busy read sets flag
// - Writing one clears double fault flag
// - Single fault sets flag unless ignored
// - Writing one clears single fault flag
// - Flags stored two cycles after read
// - Normal mode: protection may only grow
// - Special mode: any scenario move accepted
// - Reset sequence loads protection byte
// - Double fault at load: fully protected
// - Protected program or erase rejected, flagged
// - Block erase refused if sector protected
// - Polarity bit selects protect or unprotect
// - Polarity and disables give eight scenarios
// - High disable bit gates top region
// - High size code selects 2-16 KB
// - High size writable only while disabled
// - Low disable bit gates base region
// - Low size code selects 1-8 KB
// - Low size writable only while disabled
// - Interrupt while single fault flag set
// - Disallowed scenario writes ignored in normal
module fep_top
   import fep_pkg::*;
(
   // Clock, reset and clock enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Array read results
   input wire logic rd_valid,
   input wire logic rd_single_err,
   input wire logic rd_double_err,
   input wire logic rd_invalid_busy,
   // Protection byte from the reset sequence
   input wire logic nv_load,
   input wire logic [7:0] nv_prot_byte,
   input wire logic nv_double_fault,
   // Operating mode
   input wire logic special_mode,
   // Command launch
   input wire logic cmd_launch,
   input wire logic [23:0] cmd_addr,
   input wire logic cmd_block_erase,
   output logic cmd_accept,
   output logic cmd_reject,
   // Interrupt request
   output logic single_fault_irq
);

   // Bus data phase
   logic dp_valid_ff;
   logic dp_write_ff;
   logic [5:0] dp_index_ff;
   logic rd_done_ff;
   logic [31:0] hrdata_ff;
   logic bus_accept;
   logic rd_wait;
   logic wr_fire;
   logic wr_cfg;
   logic wr_ecfg;
   logic wr_stat;
   logic wr_eflg;
   logic wr_prot;

   // Fault events and flags
   logic single_ev_ff;
   logic double_ev_ff;
   logic single_fault_flag_ff;
   logic double_fault_flag_ff;
   logic irq_ff;

   // Configuration
   logic ignore_single_fault_ff;
   logic single_fault_irq_enable_ff;

   // Protection and commands
   fep_prot_t prot_ff;
   fep_prot_t nxt_prot;
   logic prot_wr_ok;
   logic protection_violation_flag_ff;
   logic cmd_accept_ff;
   logic cmd_reject_ff;
   logic cmd_blocked;

   fep_prot_if pif ();

   // Scenario number of a protection setting
   function automatic logic [2:0] fep_scen(input fep_prot_t p);
      fep_scen = {p.polarity, p.high_disable, p.low_disable};
   endfunction : fep_scen

   // Register read multiplexer
   function automatic logic [31:0] fep_read(
      input logic [5:0] idx,
      input logic [7:0] cfg,
      input logic [7:0] ecfg,
      input logic [7:0] stat,
      input logic [7:0] eflg,
      input logic [7:0] prot
   );
      fep_read = 32'h0000_0000;
      unique case (idx)
         `FEP_IDX_CONFIG: begin
            fep_read[7:0] = cfg;
         end
         `FEP_IDX_ERR_CONFIG: begin
            fep_read[7:0] = ecfg;
         end
         `FEP_IDX_STATUS: begin
            fep_read[7:0] = stat;
         end
         `FEP_IDX_ERR_FLAGS: begin
            fep_read[7:0] = eflg;
         end
         `FEP_IDX_PROT: begin
            fep_read[7:0] = prot;
         end
         default: begin
            fep_read = 32'h0000_0000;
         end
      endcase
   endfunction : fep_read

   // Write strobe of one register
   function automatic logic fep_hit(input logic fire, input logic [5:0] idx,
      input logic [5:0] reg_idx);
      fep_hit = fire && (idx == reg_idx);
   endfunction : fep_hit

   // Allowed scenario move, bit index is from times eight plus to
   function automatic logic fep_move_ok(input logic [2:0] from_scen,
      input logic [2:0] to_scen);
      logic [63:0] moves;
      moves = `FEP_TRANS_TABLE;
      fep_move_ok = moves[{from_scen, to_scen}];
   endfunction : fep_move_ok

   // Bus handshake
   assign bus_accept = hce && hsel && hready && htrans[1];
   assign rd_wait = dp_valid_ff && !dp_write_ff && !rd_done_ff;
   assign wr_fire = hce && dp_valid_ff && dp_write_ff;
   assign hreadyout = hce && !rd_wait;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;

   // Register write strobes
   assign wr_cfg = fep_hit(wr_fire, dp_index_ff, `FEP_IDX_CONFIG);
   assign wr_ecfg = fep_hit(wr_fire, dp_index_ff, `FEP_IDX_ERR_CONFIG);
   assign wr_stat = fep_hit(wr_fire, dp_index_ff, `FEP_IDX_STATUS);
   assign wr_eflg = fep_hit(wr_fire, dp_index_ff, `FEP_IDX_ERR_FLAGS);
   assign wr_prot = fep_hit(wr_fire, dp_index_ff, `FEP_IDX_PROT);

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid_ff <= 1'b0;
         dp_write_ff <= 1'b0;
         dp_index_ff <= 6'h00;
      end else if (hce && hready) begin
         dp_valid_ff <= bus_accept;
         dp_write_ff <= hwrite;
         dp_index_ff <= haddr[7:2];
      end
   end

   // Read data with one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_done_ff <= 1'b0;
         hrdata_ff <= 32'h0000_0000;
      end else if (hce) begin
         rd_done_ff <= rd_wait;
         if (rd_wait) begin
            hrdata_ff <= fep_read(dp_index_ff,
               {3'b000, ignore_single_fault_ff, 4'h0},
               {7'h00, single_fault_irq_enable_ff},
               {3'b000, protection_violation_flag_ff, 4'h0},
               {6'h00, double_fault_flag_ff, single_fault_flag_ff},
               prot_ff);
         end
      end
   end

   // Configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ignore_single_fault_ff <= 1'b0;
         single_fault_irq_enable_ff <= 1'b0;
      end else if (hce) begin
         if (wr_cfg) begin
            ignore_single_fault_ff <= hwdata[`FEP_IGNORE_SF_BIT];
         end
         if (wr_ecfg) begin
            single_fault_irq_enable_ff <= hwdata[`FEP_SF_IRQ_EN_BIT];
         end
      end
   end

   // Array read events, stored one cycle before the flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         single_ev_ff <= 1'b0;
         double_ev_ff <= 1'b0;
      end else if (hce) begin
         double_ev_ff <= rd_valid && (rd_double_err || rd_invalid_busy);
         single_ev_ff <= rd_valid && !ignore_single_fault_ff &&
            (rd_single_err || rd_invalid_busy);
      end
   end

   // Double fault flag, set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         double_fault_flag_ff <= 1'b0;
      end else if (hce) begin
         if (double_ev_ff) begin
            double_fault_flag_ff <= 1'b1;
         end else if (wr_eflg &&
            hwdata[`FEP_DOUBLE_FAULT_BIT]) begin
            double_fault_flag_ff <= 1'b0;
         end
      end
   end

   // Single fault flag, set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         single_fault_flag_ff <= 1'b0;
      end else if (hce) begin
         if (single_ev_ff) begin
            single_fault_flag_ff <= 1'b1;
         end else if (wr_eflg &&
            hwdata[`FEP_SINGLE_FAULT_BIT]) begin
            single_fault_flag_ff <= 1'b0;
         end
      end
   end

   // Interrupt request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_ff <= 1'b0;
      end else if (hce) begin
         irq_ff <= single_fault_irq_enable_ff &&
            (single_fault_flag_ff || single_ev_ff);
      end
   end

   assign single_fault_irq = irq_ff;

   // Candidate protection value of a register write
   always_comb begin
      nxt_prot = fep_prot_t'(hwdata[7:0] & `FEP_PROT_WR_MASK);
      nxt_prot.reserved_nv_bit = prot_ff.reserved_nv_bit;
      if (!prot_ff.high_disable) begin
         nxt_prot.high_size = prot_ff.high_size;
      end
      if (!prot_ff.low_disable) begin
         nxt_prot.low_size = prot_ff.low_size;
      end
   end

   // Normal mode only takes moves that keep or add protection
   assign prot_wr_ok = special_mode ||
      fep_move_ok(fep_scen(prot_ff), fep_scen(nxt_prot));

   // Protection register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prot_ff <= fep_prot_t'(`FEP_PROT_FULL);
      end else if (hce) begin
         if (nv_load) begin
            if (nv_double_fault) begin
               prot_ff <= fep_prot_t'(`FEP_PROT_FULL);
            end else begin
               prot_ff <= fep_prot_t'(nv_prot_byte);
            end
         end else if (wr_prot && prot_wr_ok) begin
            prot_ff <= nxt_prot;
         end
      end
   end

   // Range checker
   assign pif.prot = prot_ff;
   assign pif.addr = cmd_addr;

   fep_range_check u_range (
      .pif (pif.range)
   );

   // Launch refused while a violation is pending or target is protected
   assign cmd_blocked = cmd_block_erase ? pif.block_locked
      : pif.is_protected;

   // Command verdict
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_accept_ff <= 1'b0;
         cmd_reject_ff <= 1'b0;
      end else if (hce) begin
         cmd_accept_ff <= cmd_launch && !protection_violation_flag_ff && !cmd_blocked;
         cmd_reject_ff <= cmd_launch && (protection_violation_flag_ff || cmd_blocked);
      end
   end

   assign cmd_accept = cmd_accept_ff;
   assign cmd_reject = cmd_reject_ff;

   // Protection violation flag, set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         protection_violation_flag_ff <= 1'b0;
      end else if (hce) begin
         if (cmd_launch && cmd_blocked) begin
            protection_violation_flag_ff <= 1'b1;
         end else if (wr_stat &&
            hwdata[`FEP_VIOL_BIT]) begin
            protection_violation_flag_ff <= 1'b0;
         end
      end
   end

endmodule : fep_top

`default_nettype wire

// ### test/fep_top_sva.sv
// Checker of the protection block ports
`timescale 1ns/1ps
`default_nettype none

module fep_top_sva (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hce,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // Load and commands
   input wire logic nv_load,
   input wire logic nv_double_fault,
   input wire logic cmd_launch,
   input wire logic cmd_accept,
   input wire logic cmd_reject
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn || !hce);
   wire take = hsel && hready && htrans[1];

   resp_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   write_nowait_a: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   cmd_answer_a: assert property (cmd_launch |=> cmd_accept != cmd_reject)
      else $error("command not answered once");
   stray_answer_a: assert property (cmd_accept || cmd_reject |-> $past(cmd_launch))
      else $error("answer without launch");
   nv_full_a: assert property (nv_load && nv_double_fault ##1 cmd_launch |=> cmd_reject)
      else $error("faulty load left a hole");
   rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
      else $error("read data moved outside a read");
   upper_zero_a: assert property (hrdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
endmodule : fep_top_sva

`default_nettype wire

// ### test/fep_ahb_master.sv
// Bus master model of the processor core
`timescale 1ns/1ps
`default_nettype none

module fep_ahb_master (
   // Clock and bus return
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Bus request
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial begin
      hsel = 1'b1;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'hFFFF_FFFF;
   end

   // One single word transfer, byte address is index times four
   task automatic xfer(input logic [5:0] i, input logic w, input logic [31:0] d,
         output logic [31:0] q);
      haddr <= {24'h00_0000, i, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= w ? d : 32'h5A5A_5A5A;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~hwdata;
   endtask : xfer
endmodule : fep_ahb_master

`default_nettype wire

// ### test/fep_top_tb_top.sv
// Testbench of the protection block
`timescale 1ns/1ps
`default_nettype none
`include "fep_map.svh"

bind fep_top fep_top_sva u_fep_top_sva (.hclk(hclk), .hresetn(hresetn), .hce(hce),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .nv_load(nv_load), .nv_double_fault(nv_double_fault),
   .cmd_launch(cmd_launch), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject));

module fep_top_tb_top;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hce = 1'b1;
   logic hsel, hwrite, hready, hresp, rd_valid, rd_single_err, rd_double_err;
   logic rd_invalid_busy, nv_load, nv_double_fault, special_mode, cmd_launch;
   logic cmd_block_erase, cmd_accept, cmd_reject, single_fault_irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] nv_prot_byte;
   logic [23:0] cmd_addr;
   logic [31:0] haddr, hwdata, hrdata, q;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;

   always #2 hclk = ~hclk;

   fep_top u_fep_top (.hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
      .rd_valid(rd_valid), .rd_single_err(rd_single_err), .rd_double_err(rd_double_err),
      .rd_invalid_busy(rd_invalid_busy), .nv_load(nv_load), .nv_prot_byte(nv_prot_byte),
      .nv_double_fault(nv_double_fault), .special_mode(special_mode),
      .cmd_launch(cmd_launch), .cmd_addr(cmd_addr), .cmd_block_erase(cmd_block_erase),
      .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
      .single_fault_irq(single_fault_irq));

   fep_ahb_master u_fep_ahb_master (.hclk(hclk), .hready(hready), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata));

   task automatic close_out;
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      u_fep_ahb_master.xfer(i, 1'b1, d, q);
   endtask : wr

   task automatic rchk(input logic [5:0] i, input logic [31:0] e, input string nm);
      u_fep_ahb_master.xfer(i, 1'b0, 32'h0000_0000, q);
      check(nm, q, e);
   endtask : rchk

   task automatic fault(input logic s, input logic d, input logic b);
      rd_valid <= 1'b1;
      rd_single_err <= s;
      rd_double_err <= d;
      rd_invalid_busy <= b;
      @(posedge hclk);
      rd_valid <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask : fault

   task automatic nvld(input logic [7:0] b, input logic f);
      nv_load <= 1'b1;
      nv_prot_byte <= b;
      nv_double_fault <= f;
      @(posedge hclk);
      nv_load <= 1'b0;
      nv_prot_byte <= ~b;
   endtask : nvld

   // Launch, check the answer, then clear the violation flag
   task automatic cmd(input logic [23:0] a, input logic be, input logic rej);
      cmd_launch <= 1'b1;
      cmd_addr <= a;
      cmd_block_erase <= be;
      @(posedge hclk);
      cmd_launch <= 1'b0;
      @(posedge hclk);
      check("cmd_reject", {31'h0000_0000, cmd_reject}, {31'h0000_0000, rej});
      check("cmd_accept", {31'h0000_0000, cmd_accept}, {31'h0000_0000, !rej});
      rchk(`FEP_IDX_STATUS, {27'h000_0000, rej, 4'h0}, "violation");
      wr(`FEP_IDX_STATUS, 32'h0000_0010);
   endtask : cmd

   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         close_out;
      end
   end

   initial begin
      {rd_valid, rd_single_err, rd_double_err, rd_invalid_busy} = 4'h0;
      {nv_load, nv_double_fault, special_mode, cmd_launch, cmd_block_erase} = 5'h00;
      nv_prot_byte = 8'h00;
      cmd_addr = 24'h00_0000;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rchk(`FEP_IDX_PROT, 32'h0000_007F, "prot");
      rchk(6'h3F, 32'h0000_0000, "unmapped");
      nvld(8'h00, 1'b1);
      cmd(24'hFF_A000, 1'b0, 1'b1);
      rchk(`FEP_IDX_PROT, 32'h0000_007F, "prot");
      special_mode <= 1'b1;
      nvld(8'h00, 1'b0);
      rchk(`FEP_IDX_PROT, 32'h0000_0000, "prot");
      cmd(24'hFF_F800, 1'b0, 1'b0);
      cmd(24'hFF_F7FF, 1'b0, 1'b1);
      wr(`FEP_IDX_PROT, 32'h0000_00FF);
      rchk(`FEP_IDX_PROT, 32'h0000_00A4, "prot");
      wr(`FEP_IDX_PROT, 32'h0000_00FF);
      rchk(`FEP_IDX_PROT, 32'h0000_00BF, "prot");
      cmd(24'hFF_C000, 1'b1, 1'b0);
      wr(`FEP_IDX_PROT, 32'h0000_009F);
      cmd(24'hFF_C000, 1'b0, 1'b1);
      cmd(24'hFF_BFFF, 1'b0, 1'b0);
      cmd(24'hFF_8000, 1'b1, 1'b1);
      wr(`FEP_IDX_PROT, 32'h0000_00FB);
      rchk(`FEP_IDX_PROT, 32'h0000_00BB, "prot");
      cmd(24'hFF_9FFF, 1'b0, 1'b1);
      cmd(24'hFF_A000, 1'b0, 1'b0);
      special_mode <= 1'b0;
      wr(`FEP_IDX_PROT, 32'h0000_00FF);
      rchk(`FEP_IDX_PROT, 32'h0000_00BB, "prot");
      wr(`FEP_IDX_PROT, 32'h0000_003F);
      rchk(`FEP_IDX_PROT, 32'h0000_003F, "prot");
      cmd(24'hFF_A000, 1'b0, 1'b1);
      fault(1'b0, 1'b1, 1'b0);
      rchk(`FEP_IDX_ERR_FLAGS, 32'h0000_0002, "flags");
      wr(`FEP_IDX_ERR_FLAGS, 32'h0000_0000);
      rchk(`FEP_IDX_ERR_FLAGS, 32'h0000_0002, "flags");
      wr(`FEP_IDX_ERR_FLAGS, 32'h0000_0002);
      fault(1'b1, 1'b0, 1'b0);
      rchk(`FEP_IDX_ERR_FLAGS, 32'h0000_0001, "flags");
      wr(`FEP_IDX_ERR_FLAGS, 32'h0000_0002);
      rchk(`FEP_IDX_ERR_FLAGS, 32'h0000_0001, "flags");
      wr(`FEP_IDX_ERR_FLAGS, 32'h0000_0001);
      wr(`FEP_IDX_CONFIG, 32'h0000_0010);
      fault(1'b1, 1'b0, 1'b0);
      rchk(`FEP_IDX_ERR_FLAGS, 32'h0000_0000, "flags");
      wr(`FEP_IDX_CONFIG, 32'h0000_0000);
      wr(`FEP_IDX_ERR_CONFIG, 32'h0000_0001);
      fault(1'b0, 1'b0, 1'b1);
      rchk(`FEP_IDX_ERR_FLAGS, 32'h0000_0003, "flags");
      check("irq", {31'h0000_0000, single_fault_irq}, 32'h0000_0001);
      wr(`FEP_IDX_ERR_FLAGS, 32'h0000_0003);
      repeat (2) @(posedge hclk);
      check("irq", {31'h0000_0000, single_fault_irq}, 32'h0000_0000);
      hce <= 1'b0;
      fault(1'b0, 1'b1, 1'b0);
      hce <= 1'b1;
      rchk(`FEP_IDX_ERR_FLAGS, 32'h0000_0000, "frozen flags");
      close_out;
   end
endmodule : fep_top_tb_top

`default_nettype wire
